/* pkg/hp_pkg.sv */
// Shared constants and types for the host port status and flag block
package hp_pkg;

    // ----------------------------------------
    // Widths and depths
    // ----------------------------------------
    localparam int BYTE_W = 8;
    localparam int WORD_W = 24;
    localparam int ADDR_W = 3;
    localparam int VECTOR_W = 5;
    localparam int FIFO_DEPTH = 8;

    // ----------------------------------------
    // Host-visible byte map
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_VECTOR = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_BYTE_HIGH = 3'h5;
    localparam logic [ADDR_W-1:0] ADDR_BYTE_MID = 3'h6;
    localparam logic [ADDR_W-1:0] ADDR_BYTE_LOW = 3'h7;

    // ----------------------------------------
    // Control byte fields and reset values
    // ----------------------------------------
    localparam int CTRL_COMMAND_BIT = 0;
    localparam int CTRL_FLAG_A_BIT = 1;
    localparam int CTRL_FLAG_B_BIT = 2;
    localparam logic [VECTOR_W-1:0] VECTOR_RESET = 5'h00;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [WORD_W-1:0] WORD_ZERO = 24'h000000;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic read;
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] data;
    } host_bus_t;

    typedef struct packed {
        logic command_pending;
        logic request;
        logic transfer_mode;
        logic flag_b;
        logic flag_a;
        logic transmitter_ready;
        logic tx_empty;
        logic rx_full;
    } status_t;

    typedef enum logic [1:0] {PHASE_IDLE, PHASE_READ, PHASE_WRITE} host_phase_t;

endpackage : hp_pkg

/* hdl/word_fifo.sv */
// Word FIFO with registered read data, between host transmit bytes and the DSP
`timescale 1ns/1ps
module word_fifo
    import hp_pkg::*;
#(
    parameter int WIDTH = WORD_W,
    parameter int DEPTH = FIFO_DEPTH
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = PTR_W + 1;
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [CNT_W-1:0] count_reg, count_next;
    logic full_reg, full_next, empty_reg, empty_next;
    logic [WIDTH-1:0] data_reg, data_next;
    logic push, pop;

    // ----------------------------------------
    // Pointers, count and head word
    // ----------------------------------------
    always_comb
    begin
        push = in_valid && !full_reg;
        pop = out_ready && !empty_reg;
        wr_ptr_next = push ? wr_ptr_reg + PTR_W'(1) : wr_ptr_reg;
        rd_ptr_next = pop ? rd_ptr_reg + PTR_W'(1) : rd_ptr_reg;
        count_next = count_reg;
        if (push && !pop)
            count_next = count_reg + CNT_ONE;
        else if (pop && !push)
            count_next = count_reg - CNT_ONE;
        full_next = (count_next == CNT_FULL);
        empty_next = (count_next == '0);
        // Bypass covers a word written into the slot that becomes the head
        if (push && wr_ptr_reg == rd_ptr_next)
            data_next = in_data;
        else
            data_next = mem[rd_ptr_next];
    end

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr_reg] <= in_data;
        if (rst)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            full_reg <= 1'b0;
            empty_reg <= 1'b1;
            data_reg <= '0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
            full_reg <= full_next;
            empty_reg <= empty_next;
            data_reg <= data_next;
        end
    end

    assign in_ready = !full_reg;
    assign out_valid = !empty_reg;
    assign out_data = data_reg;

endmodule : word_fifo

/* hdl/host_port_status_sync.sv */
// Device side of the byte-wide host port: flags, status, command and data words
//
// What this block does
// - Transmit bytes loaded by the host reach the DSP-side receive word as one whole word.
// - The device itself sets and clears every host-visible status bit except command_pending, which the host writes through the control byte.
// - Status is readable by the host at any moment with no synchronising wait.
// - A status read may catch a changing bit and the host takes the right value on its next poll.
// - The two device-to-host flags change together, so a read mid-change shows 00 or 11, never 01 or 10.
// - Because of pipelining the device may still run a command after the host clears it.
// - Each host-written status bit is synchronised to the DSP clock on its own.
`timescale 1ns/1ps
module host_port_status_sync
    import hp_pkg::*;
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // Host pins
    input wire logic PORT_ENABLE_STROBE_N,
    input wire logic HOST_READ,
    input wire logic [ADDR_W-1:0] HOST_ADDR,
    input wire logic [BYTE_W-1:0] HOST_DATA_IN,
    output logic [BYTE_W-1:0] HOST_DATA_OUT,
    output logic HOST_DATA_OE,
    output logic SERVICE_REQUEST_LINE,
    // DSP core, host-to-DSP words
    output logic [WORD_W-1:0] DSP_SIDE_RECEIVE_WORD,
    output logic DSP_RX_FULL_BIT,
    input wire logic DSP_RECEIVE_TAKE,
    // DSP core, DSP-to-host words
    input wire logic [WORD_W-1:0] DSP_SEND_WORD,
    input wire logic DSP_SEND_VALID,
    output logic DSP_TX_EMPTY_BIT,
    // DSP core, flags, mode and command
    input wire logic DSP_TO_HOST_FLAG_A,
    input wire logic DSP_TO_HOST_FLAG_B,
    input wire logic DSP_TRANSFER_MODE,
    output logic HOST_TO_DSP_FLAG_A,
    output logic HOST_TO_DSP_FLAG_B,
    output logic DSP_COMMAND_PENDING_BIT,
    output logic [VECTOR_W-1:0] COMMAND_VECTOR_BITS,
    input wire logic DSP_COMMAND_ACK
);

    localparam int BUS_W = $bits(host_bus_t);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    host_bus_t bus_pin;
    logic [BUS_W:0] sync1_reg, sync2_reg;
    host_bus_t bus_s;
    logic enable_s_n;

    assign bus_pin = '{read: HOST_READ, addr: HOST_ADDR, data: HOST_DATA_IN};

    // One stage pair per bit, so no bit waits on another
    genvar gi;
    generate
        for (gi = 0; gi <= BUS_W; gi++)
        begin : g_sync
            logic pin_bit;
            assign pin_bit = (gi == BUS_W) ? PORT_ENABLE_STROBE_N : bus_pin[gi];
            always_ff @(posedge MCLK)
            begin
                if (RST)
                begin
                    sync1_reg[gi] <= (gi == BUS_W);
                    sync2_reg[gi] <= (gi == BUS_W);
                end
                else
                begin
                    sync1_reg[gi] <= pin_bit;
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    assign bus_s = host_bus_t'(sync2_reg[BUS_W-1:0]);
    assign enable_s_n = sync2_reg[BUS_W];

    // ----------------------------------------
    // Access phase and register state
    // ----------------------------------------
    host_phase_t phase_reg, phase_next;
    logic [ADDR_W-1:0] acc_addr_reg, acc_addr_next;
    logic [BYTE_W-1:0] acc_data_reg, acc_data_next;
    logic [BYTE_W-1:0] tx_byte_high_reg, tx_byte_high_next, tx_byte_mid_reg, tx_byte_mid_next;
    logic [WORD_W-1:0] tx_word_reg, tx_word_next, rx_word_reg, rx_word_next;
    logic tx_pending_reg, tx_pending_next, rx_full_reg, rx_full_next;
    logic cmd_pending_reg, cmd_pending_next, cmd_take_reg, cmd_take_next;
    logic [VECTOR_W-1:0] vector_reg, vector_next;
    logic host_flag_a_reg, host_flag_a_next, host_flag_b_reg, host_flag_b_next;
    logic [1:0] dsp_flags_reg, dsp_flags_next;
    status_t status_reg, status_next;
    logic [BYTE_W-1:0] data_out_reg, data_out_next;
    logic data_oe_reg, data_oe_next;
    logic request_reg, request_next;
    logic fifo_in_ready, fifo_out_valid;
    logic write_done, read_done, low_read_done;

    always_comb
    begin
        phase_next = phase_reg;
        acc_addr_next = acc_addr_reg;
        acc_data_next = acc_data_reg;
        write_done = 1'b0;
        read_done = 1'b0;
        unique case (phase_reg)
            PHASE_IDLE:
                if (!enable_s_n)
                begin
                    phase_next = bus_s.read ? PHASE_READ : PHASE_WRITE;
                    acc_addr_next = bus_s.addr;
                    acc_data_next = bus_s.data;
                end
            PHASE_READ:
                if (enable_s_n)
                begin
                    read_done = 1'b1;
                    phase_next = PHASE_IDLE;
                end
            PHASE_WRITE:
                // Data is taken while the strobe is still low, ahead of the host's short hold
                if (enable_s_n)
                begin
                    write_done = 1'b1;
                    phase_next = PHASE_IDLE;
                end
                else
                begin
                    acc_addr_next = bus_s.addr;
                    acc_data_next = bus_s.data;
                end
        endcase
        low_read_done = read_done && acc_addr_reg == ADDR_BYTE_LOW;

        tx_byte_high_next = tx_byte_high_reg;
        tx_byte_mid_next = tx_byte_mid_reg;
        tx_word_next = tx_word_reg;
        tx_pending_next = tx_pending_reg && !fifo_in_ready;
        vector_next = vector_reg;
        host_flag_a_next = host_flag_a_reg;
        host_flag_b_next = host_flag_b_reg;
        cmd_pending_next = cmd_pending_reg && !DSP_COMMAND_ACK;
        if (write_done)
        begin
            unique case (acc_addr_reg)
                ADDR_BYTE_HIGH: tx_byte_high_next = acc_data_reg;
                ADDR_BYTE_MID: tx_byte_mid_next = acc_data_reg;
                ADDR_BYTE_LOW:
                begin
                    tx_word_next = {tx_byte_high_reg, tx_byte_mid_reg, acc_data_reg};
                    tx_pending_next = 1'b1;
                end
                ADDR_VECTOR: vector_next = acc_data_reg[VECTOR_W-1:0];
                ADDR_CONTROL:
                begin
                    // Host set beats a same-cycle core acknowledge; a host clear cancels
                    cmd_pending_next = acc_data_reg[CTRL_COMMAND_BIT];
                    host_flag_a_next = acc_data_reg[CTRL_FLAG_A_BIT];
                    host_flag_b_next = acc_data_reg[CTRL_FLAG_B_BIT];
                end
                default: ;
            endcase
        end
        // Request stage lags the pending bit, so a late cancel may still be acted on
        cmd_take_next = cmd_pending_reg;

        rx_word_next = rx_word_reg;
        rx_full_next = rx_full_reg && !low_read_done;
        if (DSP_SEND_VALID && !rx_full_reg)
        begin
            rx_word_next = DSP_SEND_WORD;
            rx_full_next = 1'b1;
        end
        // Both flags sampled in one register so they flip in the same edge
        dsp_flags_next = {DSP_TO_HOST_FLAG_B, DSP_TO_HOST_FLAG_A};
        request_next = rx_full_next || !tx_pending_next;

        status_next = '{command_pending: cmd_pending_next, request: request_next,
                        transfer_mode: DSP_TRANSFER_MODE, flag_b: dsp_flags_next[1],
                        flag_a: dsp_flags_next[0], transmitter_ready: !tx_pending_next && !fifo_out_valid,
                        tx_empty: !tx_pending_next, rx_full: rx_full_next};

        // No wait state: status byte is always ready to drive
        data_oe_next = (phase_next == PHASE_READ);
        unique case (acc_addr_next)
            ADDR_STATUS: data_out_next = status_next;
            ADDR_CONTROL: data_out_next = BYTE_W'({host_flag_b_next, host_flag_a_next, cmd_pending_next});
            ADDR_VECTOR: data_out_next = BYTE_W'(vector_next);
            ADDR_BYTE_HIGH: data_out_next = rx_word_reg[WORD_W-1 -: BYTE_W];
            ADDR_BYTE_MID: data_out_next = rx_word_reg[WORD_W-BYTE_W-1 -: BYTE_W];
            ADDR_BYTE_LOW: data_out_next = rx_word_reg[BYTE_W-1:0];
            default: data_out_next = BYTE_ZERO;
        endcase
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            phase_reg <= PHASE_IDLE;
            acc_addr_reg <= '0;
            acc_data_reg <= BYTE_ZERO;
            tx_byte_high_reg <= BYTE_ZERO;
            tx_byte_mid_reg <= BYTE_ZERO;
            tx_word_reg <= WORD_ZERO;
            tx_pending_reg <= 1'b0;
            rx_word_reg <= WORD_ZERO;
            rx_full_reg <= 1'b0;
            cmd_pending_reg <= 1'b0;
            cmd_take_reg <= 1'b0;
            vector_reg <= VECTOR_RESET;
            host_flag_a_reg <= 1'b0;
            host_flag_b_reg <= 1'b0;
            dsp_flags_reg <= 2'h0;
            status_reg <= '{tx_empty: 1'b1, default: 1'b0};
            data_out_reg <= BYTE_ZERO;
            data_oe_reg <= 1'b0;
            request_reg <= 1'b0;
        end
        else
        begin
            phase_reg <= phase_next;
            acc_addr_reg <= acc_addr_next;
            acc_data_reg <= acc_data_next;
            tx_byte_high_reg <= tx_byte_high_next;
            tx_byte_mid_reg <= tx_byte_mid_next;
            tx_word_reg <= tx_word_next;
            tx_pending_reg <= tx_pending_next;
            rx_word_reg <= rx_word_next;
            rx_full_reg <= rx_full_next;
            cmd_pending_reg <= cmd_pending_next;
            cmd_take_reg <= cmd_take_next;
            vector_reg <= vector_next;
            host_flag_a_reg <= host_flag_a_next;
            host_flag_b_reg <= host_flag_b_next;
            dsp_flags_reg <= dsp_flags_next;
            status_reg <= status_next;
            data_out_reg <= data_out_next;
            data_oe_reg <= data_oe_next;
            request_reg <= request_next;
        end
    end

    // ----------------------------------------
    // Word FIFO toward the DSP core
    // ----------------------------------------
    word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(MCLK),
        .rst(RST),
        .in_valid(tx_pending_reg),
        .in_ready(fifo_in_ready),
        .in_data(tx_word_reg),
        .out_valid(fifo_out_valid),
        .out_ready(DSP_RECEIVE_TAKE),
        .out_data(DSP_SIDE_RECEIVE_WORD)
    );

    assign DSP_RX_FULL_BIT = fifo_out_valid;
    assign DSP_TX_EMPTY_BIT = !rx_full_reg;
    assign HOST_DATA_OUT = data_out_reg;
    assign HOST_DATA_OE = data_oe_reg;
    assign SERVICE_REQUEST_LINE = request_reg;
    assign HOST_TO_DSP_FLAG_A = host_flag_a_reg;
    assign HOST_TO_DSP_FLAG_B = host_flag_b_reg;
    assign DSP_COMMAND_PENDING_BIT = cmd_take_reg;
    assign COMMAND_VECTOR_BITS = vector_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    sequence s_low_write;
        write_done && acc_addr_reg == ADDR_BYTE_LOW;
    endsequence
    sequence s_word_pushed;
        tx_pending_reg && fifo_in_ready;
    endsequence

    chk_word_whole: assert property (s_low_write |=> tx_pending_reg &&
        tx_word_reg == {$past(tx_byte_high_reg), $past(tx_byte_mid_reg), $past(acc_data_reg)})
        else $error("transmit word not assembled whole");
    chk_word_drain: assert property (s_word_pushed ##0 !write_done |=> !tx_pending_reg)
        else $error("pushed word still pending");
    chk_status_bits: assert property (status_reg.rx_full == rx_full_reg &&
        status_reg.tx_empty == !tx_pending_reg && status_reg.command_pending == cmd_pending_reg)
        else $error("status byte disagrees with state");
    chk_read_nowait: assert property (phase_reg == PHASE_IDLE && !enable_s_n && bus_s.read |=>
        HOST_DATA_OE ##1 (HOST_DATA_OE || enable_s_n))
        else $error("status read not driven at once");
    chk_flag_pair: assert property (##1 {status_reg.flag_b, status_reg.flag_a} ==
        dsp_flags_reg)
        else $error("device flags not moved together");
    chk_cmd_late: assert property ($fell(cmd_pending_reg) |-> DSP_COMMAND_PENDING_BIT ##1 !DSP_COMMAND_PENDING_BIT)
        else $error("command request stage lag wrong");
    chk_sync_depth: assert property ($fell(enable_s_n) |-> $past(PORT_ENABLE_STROBE_N, 2) == 1'b0)
        else $error("strobe used before two stages");
    chk_rx_clear: assert property (low_read_done |=> !rx_full_reg)
        else $error("receive full not cleared by low byte read");
    chk_rx_stable: assert property (rx_full_reg && !low_read_done |=> $stable(rx_word_reg))
        else $error("receive bytes changed while full");

endmodule : host_port_status_sync

/* tb/host_model.sv */
// Host processor model driving the byte-wide host pins
`timescale 1ns/1ps
module host_model
    import hp_pkg::*;
(
    // Clock
    input wire logic clk,
    // Host pins
    output logic strobe_n,
    output logic read,
    output logic [ADDR_W-1:0] addr,
    output logic [BYTE_W-1:0] data,
    input wire logic [BYTE_W-1:0] data_out,
    input wire logic data_oe
);
    // ----------------------------------------
    // Bus cycle
    // ----------------------------------------
    initial
    begin
        strobe_n = 1'b1;
        read = 1'b1;
        addr = ADDR_STATUS;
        data = 8'h5a;
    end

    task automatic access(input logic rd_n, input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] d,
                          output logic [BYTE_W-1:0] q);
        @(posedge clk);
        #2;
        read = rd_n;
        addr = a;
        data = d;
        strobe_n = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        q = data_oe ? data_out : 'x;
        @(posedge clk);
        #2;
        strobe_n = 1'b1;
        // Held lines go stale once the hold time is over
        repeat (3) @(posedge clk);
        #2;
        data = ~data;
        addr = ~addr;
    endtask : access

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] d);
        logic [BYTE_W-1:0] q;
        access(1'b0, a, d, q);
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [BYTE_W-1:0] q);
        access(1'b1, a, ~data, q);
    endtask : rd

    // ----------------------------------------
    // Polled transfers
    // ----------------------------------------
    task automatic wr_word(input logic [WORD_W-1:0] w);
        logic [BYTE_W-1:0] q;
        q = 8'h00;
        for (int n = 0; n < 20 && q[1] !== 1'b1; n++)
            rd(ADDR_STATUS, q);
        wr(ADDR_BYTE_HIGH, w[23:16]);
        wr(ADDR_BYTE_MID, w[15:8]);
        wr(ADDR_BYTE_LOW, w[7:0]);
    endtask : wr_word

    task automatic rd_word(output logic [WORD_W-1:0] w);
        logic [BYTE_W-1:0] q;
        q = 8'h00;
        for (int n = 0; n < 20 && q[0] !== 1'b1; n++)
            rd(ADDR_STATUS, q);
        rd(ADDR_BYTE_HIGH, w[23:16]);
        rd(ADDR_BYTE_MID, w[15:8]);
        rd(ADDR_BYTE_LOW, w[7:0]);
    endtask : rd_word

    task automatic rd_pair(output logic [BYTE_W-1:0] q);
        logic [BYTE_W-1:0] prev;
        rd(ADDR_STATUS, prev);
        rd(ADDR_STATUS, q);
        for (int n = 0; n < 8 && q[4:3] !== prev[4:3]; n++)
        begin
            prev = q;
            rd(ADDR_STATUS, q);
        end
    endtask : rd_pair
endmodule : host_model

/* tb/host_port_status_sync_tb_top.sv */
// Self-checking testbench for the host port status and flag block
`timescale 1ns/1ps
module host_port_status_sync_tb_top
    import hp_pkg::*;
;
    logic mclk, rst, strobe_n, hread, hoe, srq, rx_full, take, send_valid, tx_empty;
    logic fa, fb, mode, hfa, hfb, cmd, ack;
    logic [ADDR_W-1:0] haddr;
    logic [BYTE_W-1:0] hdin, hdout;
    logic [WORD_W-1:0] rx_word, send_word;
    logic [VECTOR_W-1:0] vec;
    int err_total = 0;
    int comparisons = 0;

    host_port_status_sync u_dut (.MCLK(mclk), .RST(rst), .PORT_ENABLE_STROBE_N(strobe_n), .HOST_READ(hread),
        .HOST_ADDR(haddr), .HOST_DATA_IN(hdin), .HOST_DATA_OUT(hdout), .HOST_DATA_OE(hoe),
        .SERVICE_REQUEST_LINE(srq), .DSP_SIDE_RECEIVE_WORD(rx_word), .DSP_RX_FULL_BIT(rx_full),
        .DSP_RECEIVE_TAKE(take), .DSP_SEND_WORD(send_word), .DSP_SEND_VALID(send_valid),
        .DSP_TX_EMPTY_BIT(tx_empty), .DSP_TO_HOST_FLAG_A(fa), .DSP_TO_HOST_FLAG_B(fb),
        .DSP_TRANSFER_MODE(mode), .HOST_TO_DSP_FLAG_A(hfa), .HOST_TO_DSP_FLAG_B(hfb),
        .DSP_COMMAND_PENDING_BIT(cmd), .COMMAND_VECTOR_BITS(vec), .DSP_COMMAND_ACK(ack));
    host_model u_host (.clk(mclk), .strobe_n(strobe_n), .read(hread), .addr(haddr), .data(hdin),
        .data_out(hdout), .data_oe(hoe));

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic report(input string what);
        $display("Error %0t: %s mismatch", $time, what);
        err_total++;
    endtask : report

    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
            report("bit");
    endtask : chk_bit

    task automatic chk_byte(input logic [BYTE_W-1:0] got, input logic [BYTE_W-1:0] exp);
        comparisons++;
        if (got !== exp)
            report("byte");
    endtask : chk_byte

    task automatic chk_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        comparisons++;
        if (got !== exp)
            report("word");
    endtask : chk_word

    task automatic close_out;
        if (err_total == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    task automatic step;
        @(posedge mclk);
        #2;
    endtask : step

    function automatic logic [WORD_W-1:0] word_of(input int i);
        return 24'ha1b2c3 ^ WORD_W'(i * 24'h030507);
    endfunction : word_of

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        logic [BYTE_W-1:0] q;
        chk_bit(tx_empty, 1'b1);
        chk_bit(rx_full, 1'b0);
        chk_bit(srq, 1'b1);
        u_host.rd(ADDR_STATUS, q);
        chk_byte(q, 8'h46);
    endtask : t_reset

    // Host fills the FIFO past its depth while the core stalls, then the core drains it
    task automatic t_fifo;
        logic [BYTE_W-1:0] q;
        for (int i = 0; i < FIFO_DEPTH + 1; i++)
            u_host.wr_word(word_of(i));
        repeat (3) @(posedge mclk);
        u_host.rd(ADDR_STATUS, q);
        chk_byte(q & 8'h46, 8'h00);
        chk_bit(srq, 1'b0);
        for (int i = 0; i < FIFO_DEPTH + 1; i++)
        begin
            chk_bit(rx_full, 1'b1);
            chk_word(rx_word, word_of(i));
            step;
            take = 1'b1;
            step;
            take = 1'b0;
            repeat (3) @(posedge mclk);
        end
        chk_bit(rx_full, 1'b0);
        u_host.rd(ADDR_STATUS, q);
        chk_byte(q, 8'h46);
    endtask : t_fifo

    task automatic t_send;
        logic [WORD_W-1:0] w;
        step;
        send_word = 24'h5ac31e;
        send_valid = 1'b1;
        step;
        send_valid = 1'b0;
        send_word = 24'ha53ce1;
        @(posedge mclk);
        #1;
        chk_bit(tx_empty, 1'b0);
        u_host.rd_word(w);
        chk_word(w, 24'h5ac31e);
        repeat (3) @(posedge mclk);
        chk_bit(tx_empty, 1'b1);
    endtask : t_send

    task automatic t_flags;
        logic [BYTE_W-1:0] q;
        for (int i = 0; i < 4; i++)
        begin
            step;
            fb = i[1];
            fa = i[1];
            mode = i[0];
            u_host.rd_pair(q);
            chk_byte(q, {2'b01, i[0], i[1], i[1], 3'b110});
        end
    endtask : t_flags

    task automatic t_command;
        logic [BYTE_W-1:0] q;
        u_host.wr(ADDR_VECTOR, 8'h13);
        u_host.wr(ADDR_CONTROL, 8'h07);
        repeat (3) @(posedge mclk);
        chk_bit(cmd, 1'b1);
        chk_byte({3'b000, vec}, 8'h13);
        chk_bit(hfb, 1'b1);
        u_host.rd(ADDR_STATUS, q);
        chk_bit(q[7], 1'b1);
        u_host.wr(ADDR_CONTROL, 8'h02);
        repeat (3) @(posedge mclk);
        chk_bit(cmd, 1'b0);
        chk_bit(hfa, 1'b1);
        chk_bit(hfb, 1'b0);
        u_host.wr(ADDR_CONTROL, 8'h01);
        repeat (3) @(posedge mclk);
        chk_bit(cmd, 1'b1);
        step;
        ack = 1'b1;
        step;
        ack = 1'b0;
        repeat (2) @(posedge mclk);
        chk_bit(cmd, 1'b0);
        u_host.rd(ADDR_VECTOR, q);
        chk_byte(q, 8'h13);
        u_host.rd(3'h3, q);
        chk_byte(q, 8'h00);
    endtask : t_command

    // ----------------------------------------
    // Clock, reset, sequence, watchdog
    // ----------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    initial
    begin
        rst = 1'b1;
        take = 1'b0;
        send_valid = 1'b0;
        send_word = WORD_ZERO;
        fa = 1'b0;
        fb = 1'b0;
        mode = 1'b0;
        ack = 1'b0;
        repeat (16) @(posedge mclk);
        #2;
        rst = 1'b0;
        repeat (2) @(posedge mclk);
        t_reset;
        t_fifo;
        t_send;
        t_flags;
        t_command;
        close_out();
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (40000) @(posedge mclk);
        err_total++;
        close_out();
    end
endmodule : host_port_status_sync_tb_top
